/* usbdev_pkg.sv */
// shared constants of the usb device control and event logic
package usbdev_pkg;
	localparam logic [31:0] ADDR_ENGINE_CONTROL = 32'hfff06000;
	localparam logic [31:0] ADDR_REPLY_LENGTH = 32'hfff06004;
	localparam logic [31:0] ADDR_IRQ_ENABLE = 32'hfff06008;
	localparam logic [31:0] ADDR_IRQ_FLAGS = 32'hfff6000c;
	localparam logic [31:0] ADDR_IRQ_CLEAR = 32'hfff60010;

	localparam int CTL_WIDTH = 8;
	localparam int CTL_ENGINE_ENABLE = 0;
	localparam int CTL_SOFT_RESET = 1;
	localparam int CTL_IDLE_SLEEP_EN = 2;
	localparam int CTL_WAKEUP_EN = 3;
	localparam int CTL_FAST_IDLE = 4;
	localparam int CTL_RX_SELECT = 5;
	localparam int CTL_VENDOR_DECODE = 6;
	localparam int CTL_CLASS_DECODE = 7;
	localparam int REPLY_COUNT_WIDTH = 5;
	localparam int EVENT_COUNT = 16;

	localparam logic [7:0] CTL_RESET = 8'h00;
	localparam logic [4:0] REPLY_RESET = 5'h00;
	localparam logic [15:0] EVENT_RESET = 16'h0000;

	localparam int EV_BUS_RESET = 0;
	localparam int EV_IDLE_SLEEP = 1;
	localparam int EV_WAKE = 2;
	localparam int EV_FAULT = 3;
	localparam int EV_DEVICE_DESC = 4;
	localparam int EV_CONFIG_DESC = 5;
	localparam int EV_TEXT_DESC = 6;
	localparam int EV_CLASS_REQ = 7;
	localparam int EV_VENDOR_REQ = 8;
	localparam int EV_DATA_OUT = 9;
	localparam int EV_DATA_IN = 10;
	localparam int EV_STATUS_PHASE = 11;
	localparam int EV_BUS_TRANSITION = 12;
	localparam int EV_CONFIGURED = 13;
	localparam int EV_BUS_RESET_END = 14;
	localparam int EV_CLOCKLESS_WAKE = 15;

	localparam int CLK_PERIOD_NS = 25;
	localparam int CLK_MHZ = 40;
	localparam int IDLE_SLEEP_TIME_US = 3000;
	localparam int IDLE_SLEEP_CYCLES = IDLE_SLEEP_TIME_US * CLK_MHZ;
	localparam int FAST_IDLE_TIME_US = 10;
	localparam int FAST_IDLE_CYCLES = FAST_IDLE_TIME_US * CLK_MHZ;
	localparam int RESET_SE0_TIME_NS = 2500;
	localparam int RESET_SE0_CYCLES = (RESET_SE0_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		REQ_STANDARD = 2'h0,
		REQ_CLASS = 2'h1,
		REQ_VENDOR = 2'h2
	} req_kind_t;
endpackage

/* usbdev_line_watch.sv */
// bus line watcher: pin sync, bus reset, idle sleep, wake and transition detect
`timescale 1ns/10ps
module usbdev_line_watch #(
	parameter int IDLE_CYCLES = usbdev_pkg::IDLE_SLEEP_CYCLES,
	parameter int FAST_CYCLES = usbdev_pkg::FAST_IDLE_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic dp_pin,
	input wire logic dm_pin,
	input wire logic line_enable,
	input wire logic idle_enable,
	input wire logic fast_idle,
	output logic dp_sync,
	output logic suspended,
	output logic bus_reset_ev,
	output logic reset_end_ev,
	output logic idle_sleep_ev,
	output logic wake_ev,
	output logic transition_ev
);
	localparam int CW = $clog2(IDLE_CYCLES + 1);
	localparam int SW = $clog2(usbdev_pkg::RESET_SE0_CYCLES + 1);

	initial begin
		if (FAST_CYCLES < 1 || IDLE_CYCLES < FAST_CYCLES)
			$error("idle cycle counts out of range");
	end

	typedef struct packed {
		logic dp_s1;
		logic dp_s2;
		logic dm_s1;
		logic dm_s2;
		logic [1:0] prev_line;
		logic [CW-1:0] idle_cnt;
		logic [SW-1:0] se0_cnt;
		logic in_reset;
		logic suspended;
		logic bus_reset_ev;
		logic reset_end_ev;
		logic idle_sleep_ev;
		logic wake_ev;
		logic transition_ev;
	} lw_state_t;

	lw_state_t st_r, st_nxt;
	logic [1:0] line;
	logic [CW-1:0] limit;

	always_comb begin
		st_nxt = st_r;
		st_nxt.dp_s1 = dp_pin;
		st_nxt.dp_s2 = st_r.dp_s1;
		st_nxt.dm_s1 = dm_pin;
		st_nxt.dm_s2 = st_r.dm_s1;
		line = {st_r.dp_s2, st_r.dm_s2};
		limit = fast_idle ? CW'(FAST_CYCLES) : CW'(IDLE_CYCLES);
		st_nxt.prev_line = line;
		st_nxt.bus_reset_ev = 1'b0;
		st_nxt.reset_end_ev = 1'b0;
		st_nxt.idle_sleep_ev = 1'b0;
		st_nxt.wake_ev = 1'b0;
		st_nxt.transition_ev = 1'b0;
		if (!line_enable) begin
			st_nxt.idle_cnt = '0;
			st_nxt.se0_cnt = '0;
			st_nxt.in_reset = 1'b0;
			st_nxt.suspended = 1'b0;
		end else begin
			st_nxt.transition_ev = (line != st_r.prev_line);
			if (line == 2'b00) begin
				if (st_r.se0_cnt < SW'(usbdev_pkg::RESET_SE0_CYCLES))
					st_nxt.se0_cnt = st_r.se0_cnt + SW'(1);
				else if (!st_r.in_reset) begin
					st_nxt.in_reset = 1'b1;
					st_nxt.bus_reset_ev = 1'b1;
				end
			end else begin
				st_nxt.se0_cnt = '0;
				if (st_r.in_reset) begin
					st_nxt.in_reset = 1'b0;
					st_nxt.reset_end_ev = 1'b1;
				end
			end
			if (!idle_enable) begin
				st_nxt.idle_cnt = '0;
				st_nxt.suspended = 1'b0;
			end else if (st_r.suspended) begin
				st_nxt.idle_cnt = '0;
				if (line != 2'b10) begin
					st_nxt.suspended = 1'b0;
					st_nxt.wake_ev = 1'b1;
				end
			end else if (line == 2'b10) begin
				st_nxt.idle_cnt = st_r.idle_cnt + CW'(1);
				if (st_r.idle_cnt + CW'(1) >= limit) begin
					st_nxt.suspended = 1'b1;
					st_nxt.idle_sleep_ev = 1'b1;
				end
			end else begin
				st_nxt.idle_cnt = '0;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign dp_sync = st_r.dp_s2;
	assign suspended = st_r.suspended;
	assign bus_reset_ev = st_r.bus_reset_ev;
	assign reset_end_ev = st_r.reset_end_ev;
	assign idle_sleep_ev = st_r.idle_sleep_ev;
	assign wake_ev = st_r.wake_ev;
	assign transition_ev = st_r.transition_ev;
endmodule

/* usbdev_event_flags.sv */
// sticky event flags with write-one clear and masked interrupt output
`timescale 1ns/10ps
module usbdev_event_flags #(
	parameter int N = usbdev_pkg::EVENT_COUNT
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [N-1:0] set_pulse,
	input wire logic [N-1:0] clear_mask,
	input wire logic [N-1:0] enable_mask,
	output logic [N-1:0] flags,
	output logic irq
);
	initial begin
		if (N < 1 || N > 32)
			$error("event count out of range");
	end

	typedef struct packed {
		logic [N-1:0] flags;
		logic irq;
	} ef_state_t;

	ef_state_t st_r, st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.flags = (st_r.flags & ~clear_mask) | set_pulse;
		st_nxt.irq = |(st_nxt.flags & enable_mask);
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign flags = st_r.flags;
	assign irq = st_r.irq;
endmodule

/* usbdev_ctrl_regs.sv */
// usb device control, request screening and event register block
// Summary of operation
// - class decode off: class requests are not decoded and get a stall reply.
// - class decode on: class requests are decoded and raise the class event.
// - vendor decode off: vendor requests are not decoded and get a stall reply.
// - vendor decode on: vendor requests are decoded and raise the vendor event.
// - receive select 0 takes engine receive signal, 1 takes the transceiver.
// - fast idle test bit shortens idle-sleep detection time, test use only.
// - remote wake-up drive works only while its enable bit is set.
// - idle-sleep detection works only while its enable bit is set.
// - soft reset bit 1 holds the engine in reset, 0 releases it.
// - engine enable 0 hides the device; 1 presents it for attachment.
// - five-bit reply byte count for class, vendor and descriptor replies.
// - enable bit gates the bus reset end interrupt.
// - configured event fires on configure and de-configure, with its enable.
// - separate clock-stopped wake event with its own enable bit.
// - separate enabled events for data-out, data-in and status phases.
// - separate enabled events for device, configuration and text descriptor requests.
// - enabled events for bus reset, idle sleep, wake and fault detection.
// - read-only flags show each of sixteen events at its enable position.
// - control, reply length, enable and flag registers reset to zero.
// - writing 1 to a clear bit clears that flag; 0 leaves it.
`timescale 1ns/10ps
module usbdev_ctrl_regs #(
	parameter int IDLE_SLEEP_CYCLES = usbdev_pkg::IDLE_SLEEP_CYCLES
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic reg_sel,
	input wire logic reg_write,
	input wire logic [31:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	output logic reg_ack,
	output logic reg_err,
	input wire logic dp_pin,
	input wire logic dm_pin,
	input wire logic engine_rx_diff,
	input wire logic req_valid,
	input wire logic [1:0] req_kind,
	input wire logic device_desc_req,
	input wire logic config_desc_req,
	input wire logic text_desc_req,
	input wire logic data_out_phase,
	input wire logic data_in_phase,
	input wire logic status_phase,
	input wire logic configured_change,
	input wire logic fault_detect,
	input wire logic clockless_wake,
	input wire logic wake_request,
	output logic attach_pullup,
	output logic engine_hold_reset,
	output logic rx_diff,
	output logic stall_reply,
	output logic [4:0] reply_byte_count,
	output logic bus_suspended,
	output logic remote_wake_drive,
	output logic irq
);
	localparam int EN = usbdev_pkg::EVENT_COUNT;

	initial begin
		if (IDLE_SLEEP_CYCLES < usbdev_pkg::FAST_IDLE_CYCLES)
			$error("idle sleep count below fast test count");
	end

	function automatic logic addr_is(input logic [31:0] a, input logic [31:0] ref_addr);
		addr_is = (a == ref_addr);
	endfunction

	typedef struct packed {
		logic [usbdev_pkg::CTL_WIDTH-1:0] ctl;
		logic [usbdev_pkg::REPLY_COUNT_WIDTH-1:0] reply_count;
		logic [EN-1:0] irq_en;
		logic [31:0] rdata;
		logic ack;
		logic err;
		logic stall;
		logic rx_diff;
		logic wake_drive;
	} top_state_t;

	top_state_t st_r, st_nxt;
	logic [1:0] rst_sync_r;
	logic rst_n;
	logic [EN-1:0] ev_set;
	logic [EN-1:0] ev_clear;
	logic [EN-1:0] ev_flags;
	logic engine_active;
	logic dp_sync;
	logic suspended;
	logic lw_reset_ev;
	logic lw_reset_end_ev;
	logic lw_sleep_ev;
	logic lw_wake_ev;
	logic lw_trans_ev;
	logic class_req;
	logic vendor_req;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			rst_sync_r <= 2'b00;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end
	assign rst_n = rst_sync_r[1];

	assign engine_active = st_r.ctl[usbdev_pkg::CTL_ENGINE_ENABLE]
		& ~st_r.ctl[usbdev_pkg::CTL_SOFT_RESET];
	assign class_req = engine_active & req_valid
		& (req_kind == usbdev_pkg::REQ_CLASS);
	assign vendor_req = engine_active & req_valid
		& (req_kind == usbdev_pkg::REQ_VENDOR);

	usbdev_line_watch #(
		.IDLE_CYCLES(IDLE_SLEEP_CYCLES),
		.FAST_CYCLES(usbdev_pkg::FAST_IDLE_CYCLES)
	) u_line_watch (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.dp_pin(dp_pin),
		.dm_pin(dm_pin),
		.line_enable(engine_active),
		.idle_enable(st_r.ctl[usbdev_pkg::CTL_IDLE_SLEEP_EN]),
		.fast_idle(st_r.ctl[usbdev_pkg::CTL_FAST_IDLE]),
		.dp_sync(dp_sync),
		.suspended(suspended),
		.bus_reset_ev(lw_reset_ev),
		.reset_end_ev(lw_reset_end_ev),
		.idle_sleep_ev(lw_sleep_ev),
		.wake_ev(lw_wake_ev),
		.transition_ev(lw_trans_ev)
	);

	always_comb begin
		ev_set = '0;
		ev_set[usbdev_pkg::EV_BUS_RESET] = lw_reset_ev;
		ev_set[usbdev_pkg::EV_IDLE_SLEEP] = lw_sleep_ev;
		ev_set[usbdev_pkg::EV_WAKE] = lw_wake_ev;
		ev_set[usbdev_pkg::EV_FAULT] = engine_active & fault_detect;
		ev_set[usbdev_pkg::EV_DEVICE_DESC] = engine_active & device_desc_req;
		ev_set[usbdev_pkg::EV_CONFIG_DESC] = engine_active & config_desc_req;
		ev_set[usbdev_pkg::EV_TEXT_DESC] = engine_active & text_desc_req;
		ev_set[usbdev_pkg::EV_CLASS_REQ] = class_req
			& st_r.ctl[usbdev_pkg::CTL_CLASS_DECODE];
		ev_set[usbdev_pkg::EV_VENDOR_REQ] = vendor_req
			& st_r.ctl[usbdev_pkg::CTL_VENDOR_DECODE];
		ev_set[usbdev_pkg::EV_DATA_OUT] = engine_active & data_out_phase;
		ev_set[usbdev_pkg::EV_DATA_IN] = engine_active & data_in_phase;
		ev_set[usbdev_pkg::EV_STATUS_PHASE] = engine_active & status_phase;
		ev_set[usbdev_pkg::EV_BUS_TRANSITION] = lw_trans_ev;
		ev_set[usbdev_pkg::EV_CONFIGURED] = engine_active & configured_change;
		ev_set[usbdev_pkg::EV_BUS_RESET_END] = lw_reset_end_ev;
		ev_set[usbdev_pkg::EV_CLOCKLESS_WAKE] = clockless_wake;
	end

	always_comb begin
		ev_clear = '0;
		if (reg_sel && reg_write && addr_is(reg_addr, usbdev_pkg::ADDR_IRQ_CLEAR))
			ev_clear = reg_wdata[EN-1:0];
	end

	usbdev_event_flags #(
		.N(EN)
	) u_event_flags (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.set_pulse(ev_set),
		.clear_mask(ev_clear),
		.enable_mask(st_r.irq_en),
		.flags(ev_flags),
		.irq(irq)
	);

	always_comb begin
		st_nxt = st_r;
		st_nxt.ack = 1'b0;
		st_nxt.err = 1'b0;
		st_nxt.rdata = '0;
		if (reg_sel) begin
			st_nxt.ack = 1'b1;
			if (addr_is(reg_addr, usbdev_pkg::ADDR_ENGINE_CONTROL)) begin
				if (reg_write)
					st_nxt.ctl = reg_wdata[usbdev_pkg::CTL_WIDTH-1:0];
				else
					st_nxt.rdata = {24'h000000, st_r.ctl};
			end else if (addr_is(reg_addr, usbdev_pkg::ADDR_REPLY_LENGTH)) begin
				if (reg_write)
					st_nxt.reply_count = reg_wdata[usbdev_pkg::REPLY_COUNT_WIDTH-1:0];
				else
					st_nxt.rdata = {27'h0000000, st_r.reply_count};
			end else if (addr_is(reg_addr, usbdev_pkg::ADDR_IRQ_ENABLE)) begin
				if (reg_write)
					st_nxt.irq_en = reg_wdata[EN-1:0];
				else
					st_nxt.rdata = {16'h0000, st_r.irq_en};
			end else if (addr_is(reg_addr, usbdev_pkg::ADDR_IRQ_FLAGS)) begin
				if (!reg_write)
					st_nxt.rdata = {16'h0000, ev_flags};
			end else if (!addr_is(reg_addr, usbdev_pkg::ADDR_IRQ_CLEAR)) begin
				st_nxt.err = 1'b1;
			end
		end
		st_nxt.stall = (class_req & ~st_r.ctl[usbdev_pkg::CTL_CLASS_DECODE])
			| (vendor_req & ~st_r.ctl[usbdev_pkg::CTL_VENDOR_DECODE]);
		st_nxt.rx_diff = st_r.ctl[usbdev_pkg::CTL_RX_SELECT] ? dp_sync : engine_rx_diff;
		st_nxt.wake_drive = suspended & wake_request
			& st_r.ctl[usbdev_pkg::CTL_WAKEUP_EN];
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
			st_r.ctl <= usbdev_pkg::CTL_RESET;
			st_r.reply_count <= usbdev_pkg::REPLY_RESET;
			st_r.irq_en <= usbdev_pkg::EVENT_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata = st_r.rdata;
	assign reg_ack = st_r.ack;
	assign reg_err = st_r.err;
	assign attach_pullup = st_r.ctl[usbdev_pkg::CTL_ENGINE_ENABLE];
	assign engine_hold_reset = st_r.ctl[usbdev_pkg::CTL_SOFT_RESET];
	assign rx_diff = st_r.rx_diff;
	assign stall_reply = st_r.stall;
	assign reply_byte_count = st_r.reply_count;
	assign bus_suspended = suspended;
	assign remote_wake_drive = st_r.wake_drive;
endmodule

/* usbdev_ctrl_regs_sva.sv */
// checker for the usb device control and event register block
`timescale 1ns/10ps
module usbdev_ctrl_regs_sva (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic reg_sel,
	input wire logic reg_write,
	input wire logic [31:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_ack,
	input wire logic reg_err,
	input wire logic engine_rx_diff,
	input wire logic req_valid,
	input wire logic [1:0] req_kind,
	input wire logic wake_request,
	input wire logic attach_pullup,
	input wire logic engine_hold_reset,
	input wire logic rx_diff,
	input wire logic stall_reply,
	input wire logic [4:0] reply_byte_count,
	input wire logic bus_suspended,
	input wire logic remote_wake_drive
);
	logic [7:0] ctl_r;
	wire mapped = reg_addr inside {usbdev_pkg::ADDR_ENGINE_CONTROL, usbdev_pkg::ADDR_REPLY_LENGTH,
		usbdev_pkg::ADDR_IRQ_ENABLE, usbdev_pkg::ADDR_IRQ_FLAGS, usbdev_pkg::ADDR_IRQ_CLEAR};
	wire wr_ctl = reg_sel && reg_write && reg_addr == usbdev_pkg::ADDR_ENGINE_CONTROL;
	wire wr_len = reg_sel && reg_write && reg_addr == usbdev_pkg::ADDR_REPLY_LENGTH;
	// shadow of the control byte, written at the same edge as the design
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ctl_r <= 8'h00;
		end else if (wr_ctl) begin
			ctl_r <= reg_wdata[7:0];
		end
	end
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);
	sequence s_refused;
		req_valid && ctl_r[0] && !ctl_r[1] && ((req_kind == usbdev_pkg::REQ_CLASS && !ctl_r[7])
			|| (req_kind == usbdev_pkg::REQ_VENDOR && !ctl_r[6]));
	endsequence
	sequence s_accepted;
		req_valid && ((req_kind == usbdev_pkg::REQ_CLASS && ctl_r[7])
			|| (req_kind == usbdev_pkg::REQ_VENDOR && ctl_r[6]));
	endsequence
	a_ack_and_err: assert property (reg_sel |=> reg_ack && (reg_err == !$past(mapped)))
		else $error("access answer or error flag wrong");
	a_ack_needs_sel: assert property (reg_ack |-> $past(reg_sel))
		else $error("answer without access");
	a_attach_bit: assert property (wr_ctl |=> attach_pullup == $past(reg_wdata[0]))
		else $error("attach output does not follow enable bit");
	a_hold_bit: assert property (wr_ctl |=> engine_hold_reset == $past(reg_wdata[1]))
		else $error("engine hold does not follow soft reset bit");
	a_reply_count: assert property (wr_len |=> reply_byte_count == $past(reg_wdata[4:0]))
		else $error("reply byte count not written");
	a_refused_stall: assert property (s_refused |=> stall_reply)
		else $error("refused request without stall");
	a_accepted_quiet: assert property (s_accepted |=> !stall_reply)
		else $error("decoded request was stalled");
	a_stall_cause: assert property (stall_reply |->
		$past(req_valid) && $past(req_kind) != usbdev_pkg::REQ_STANDARD)
		else $error("stall without class or vendor request");
	a_rx_engine: assert property ($past(ctl_r[5]) == 1'b0 |-> rx_diff == $past(engine_rx_diff))
		else $error("receive signal not from engine");
	a_wake_drive: assert property (remote_wake_drive |->
		$past(bus_suspended) && $past(wake_request) && $past(ctl_r[3]))
		else $error("remote wake driven without cause");
	a_suspend_enabled: assert property ($rose(bus_suspended) |-> $past(ctl_r[2]))
		else $error("suspend entered while detection disabled");
endmodule
bind usbdev_ctrl_regs usbdev_ctrl_regs_sva i_usbdev_ctrl_regs_sva (.clk_sys, .resetn, .reg_sel,
	.reg_write, .reg_addr, .reg_wdata, .reg_ack, .reg_err, .engine_rx_diff, .req_valid, .req_kind,
	.wake_request, .attach_pullup, .engine_hold_reset, .rx_diff, .stall_reply, .reply_byte_count,
	.bus_suspended, .remote_wake_drive);

/* usb_host_model.sv */
// usb host model driving the bus lines
`timescale 1ns/10ps
module usb_host_model (
	input wire logic clk_sys,
	input wire logic attach_pullup,
	output wire logic dp_pin,
	output wire logic dm_pin
);
	logic drive = 1'b0;
	logic dp_d = 1'b0;
	logic dm_d = 1'b0;
	// released lines: device pull-up on dp when attached, host pull-downs otherwise
	assign dp_pin = drive ? dp_d : attach_pullup;
	assign dm_pin = drive ? dm_d : 1'b0;
	// hold a line state for a number of cycles, then release
	task automatic drive_line(input logic dp, input logic dm, input int cycles);
		dp_d = dp;
		dm_d = dm;
		drive = 1'b1;
		repeat (cycles) @(posedge clk_sys);
		#2 drive = 1'b0;
	endtask
endmodule

/* testbench.sv */
// testbench for the usb device control and event registers
`timescale 1ns/10ps
module testbench;
	logic clk_sys, resetn, reg_sel, reg_write, engine_rx_diff, wake_request;
	logic [31:0] reg_addr, reg_wdata, reg_rdata, rd;
	logic reg_ack, reg_err, dp_pin, dm_pin, attach_pullup, engine_hold_reset, rx_diff;
	logic stall_reply, bus_suspended, remote_wake_drive, irq;
	logic [4:0] reply_byte_count;
	logic [15:0] ev;
	logic stall_seen, er;
	int n_errors = 0;
	int total_checks = 0;
	int evs [11] = '{3, 4, 5, 6, 7, 8, 9, 10, 11, 13, 15};
	// control, reply length, enable, flags, clear
	logic [31:0] adr [5] = '{usbdev_pkg::ADDR_ENGINE_CONTROL, usbdev_pkg::ADDR_REPLY_LENGTH,
		usbdev_pkg::ADDR_IRQ_ENABLE, usbdev_pkg::ADDR_IRQ_FLAGS, usbdev_pkg::ADDR_IRQ_CLEAR};
	usbdev_ctrl_regs #(.IDLE_SLEEP_CYCLES(500)) i_usbdev_ctrl_regs (.clk_sys, .resetn, .reg_sel,
		.reg_write, .reg_addr, .reg_wdata, .reg_rdata, .reg_ack, .reg_err, .dp_pin, .dm_pin,
		.engine_rx_diff, .req_valid(ev[7] | ev[8]), .req_kind({ev[8], ev[7] & ~ev[8]}),
		.device_desc_req(ev[4]), .config_desc_req(ev[5]), .text_desc_req(ev[6]),
		.data_out_phase(ev[9]), .data_in_phase(ev[10]), .status_phase(ev[11]),
		.configured_change(ev[13]), .fault_detect(ev[3]), .clockless_wake(ev[15]),
		.wake_request, .attach_pullup, .engine_hold_reset, .rx_diff, .stall_reply,
		.reply_byte_count, .bus_suspended, .remote_wake_drive, .irq);
	usb_host_model i_usb_host_model (.clk_sys, .attach_pullup, .dp_pin, .dm_pin);
	initial begin
		clk_sys = 0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	task automatic step;
		@(posedge clk_sys);
		#2;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic access(input logic wr, input logic [31:0] addr, input logic [31:0] data);
		reg_sel = 1;
		reg_write = wr;
		reg_addr = addr;
		reg_wdata = data;
		step;
		reg_sel = 0;
		rd = reg_rdata;
		er = reg_err;
		check(reg_ack, 1);
		step;
	endtask
	task automatic pulse(input int idx);
		ev[idx] = 1;
		step;
		stall_seen = stall_reply;
		ev = 0;
		step;
	endtask
	task automatic finish_test;
		$display("errors %0d checks %0d", n_errors, total_checks);
		if (n_errors == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#(25 * 5000);
		n_errors++;
		finish_test;
	end
	initial begin
		resetn = 0;
		reg_sel = 0;
		reg_write = 0;
		reg_addr = 0;
		reg_wdata = 0;
		ev = 0;
		engine_rx_diff = 0;
		wake_request = 0;
		repeat (10) @(posedge clk_sys);
		#2 resetn = 1;
		repeat (3) step;
		foreach (adr[i]) begin
			access(0, adr[i], 0);
			check(rd, 0);
		end
		access(0, 32'hfff0600c, 0);
		check(er, 1);
		access(1, adr[1], '1);
		check(reply_byte_count, 5'h1f);
		access(0, adr[1], 0);
		check(rd, 32'h0000001f);
		access(1, adr[2], '1);
		access(0, adr[2], 0);
		check(rd, 32'h0000ffff);
		access(1, adr[3], '1);
		access(0, adr[3], 0);
		check(rd, 0);
		access(1, adr[0], 32'hc1);
		check(attach_pullup, 1);
		check(dp_pin, 1);
		repeat (4) step;
		access(1, adr[4], '1);
		// each engine event sets its own flag and the interrupt
		foreach (evs[i]) begin
			pulse(evs[i]);
			check(irq, 1);
			access(0, adr[3], 0);
			check(rd, 32'h1 << evs[i]);
			access(1, adr[4], 32'h1 << evs[i]);
			access(0, adr[3], 0);
			check(rd, 0);
			check(irq, 0);
		end
		access(1, adr[2], 0);
		pulse(3);
		pulse(13);
		check(irq, 0);
		access(1, adr[4], 32'h8);
		access(0, adr[3], 0);
		check(rd, 32'h2000);
		access(1, adr[2], 32'h2000);
		step;
		check(irq, 1);
		access(1, adr[4], '1);
		access(1, adr[0], 32'hc3);
		pulse(3);
		check(engine_hold_reset, 1);
		access(0, adr[3], 0);
		check(rd, 0);
		access(1, adr[0], 32'h01);
		check(engine_hold_reset, 0);
		pulse(7);
		check(stall_seen, 1);
		pulse(8);
		check(stall_seen, 1);
		access(0, adr[3], 0);
		check(rd, 0);
		engine_rx_diff = 1;
		repeat (2) step;
		check(rx_diff, 1);
		engine_rx_diff = 0;
		access(1, adr[0], 32'h21);
		repeat (4) step;
		check(rx_diff, 1);
		// bus reset, fast idle sleep, remote wake and resume from the host
		access(1, adr[0], 32'h1d);
		access(1, adr[4], '1);
		access(1, adr[2], '1);
		i_usb_host_model.drive_line(0, 0, 120);
		repeat (450) step;
		check(bus_suspended, 1);
		wake_request = 1;
		repeat (2) step;
		check(remote_wake_drive, 1);
		i_usb_host_model.drive_line(0, 1, 5);
		repeat (4) step;
		access(0, adr[3], 0);
		check(rd, 32'h5007);
		check(irq, 1);
		finish_test;
	end
endmodule
